// file: logic/rxops_buf.sv
// Two-entry buffer with valid and ready on both sides.
// Assumes a single clock and that the filler honours in_ready.
`timescale 1ns/1ps
module rxops_buf #(
  parameter int W     = 19,
  parameter int DEPTH = 2
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  if (DEPTH != 2) begin : g_depth_check
    $error("rxops_buf serves only two entries");
  end

  logic [W-1:0] mem [DEPTH];
  logic         wp;
  logic         rp;
  logic [1:0]   cnt;

  // Full and empty straight from the occupancy count
  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;
  assign in_ready  = (cnt != 2'h2);
  assign out_valid = (cnt != 2'h0);
  assign out_data  = mem[rp];

  // Pointers and count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp  <= 1'b0;
      rp  <= 1'b0;
      cnt <= 2'h0;
    end else begin
      wp  <= wp ^ push;
      rp  <= rp ^ pop;
      cnt <= cnt + {1'b0, push} - {1'b0, pop};
    end
  end

  // Storage carries no reset; only valid entries are read
  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end
endmodule

// file: logic/rxops_cfg.svh
// Constants for the receiver output port select block.
// Assumes inclusion by both the package users and the top module.
`ifndef RXOPS_CFG_SVH
`define RXOPS_CFG_SVH

// Register indices; byte address is four times the index
`define RXOPS_IDX_PAR_A    6'h1a
`define RXOPS_IDX_LNK_A    6'h1b
`define RXOPS_IDX_PAR_B    6'h1c
`define RXOPS_IDX_LNK_B    6'h1d
`define RXOPS_IDX_CLK      6'h1e
`define RXOPS_IDX_STATUS   6'h1f
`define RXOPS_REG_RESET    8'h00

// Control bit positions
`define RXOPS_BIT_SRC      0
`define RXOPS_BIT_FMT      5
`define RXOPS_BIT_LNK_EN   7
`define RXOPS_BIT_MODE     1
`define RXOPS_BIT_NOGAIN   2
`define RXOPS_DLY_LSB      3
`define RXOPS_DLY_MSB      6
`define RXOPS_BIT_MASTER   0
`define RXOPS_DIV_LSB      1
`define RXOPS_DIV_MSB      2
`define RXOPS_EN_LSB       1
`define RXOPS_AGC_EN_MSB   2
`define RXOPS_CH_EN_MSB    4

// Link start delay floor, in receiver clock cycles
`define RXOPS_DELAY_MIN    4'h6
// Words per link quad-word when gain is included
`define RXOPS_QUAD_WORDS   4'h8
`define RXOPS_IQ_WORDS     4'h2
`define RXOPS_AGC_BASE     3'h4

`endif

// file: logic/rxops_clkdiv.sv
// Port clock generator: divides the master clock by one to four.
// Assumes the divide code only changes while the port is idle.
`timescale 1ns/1ps
module rxops_clkdiv (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [1:0] div_code,
  input  wire logic       master,
  output logic            port_clk_o,
  output logic            port_clk_oe_n
);
  logic [1:0] phase;
  logic       hi;

  // Phase counter runs 0..div_code, high for the first half
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= 2'h0;
      hi    <= 1'b0;
    end else begin
      phase <= (phase >= div_code) ? 2'h0 : phase + 2'h1;
      // Widened so the half-period compare cannot wrap at divide by three or four
      hi    <= (phase >= div_code) ||
               (({1'b0, phase} + 3'h1) < (({1'b0, div_code} + 3'h2) >> 1));
    end
  end

  // Divide by one passes the clock itself; no flop can run that fast
  assign port_clk_o    = (div_code == 2'h0) ? pclk : hi;
  assign port_clk_oe_n = ~master;

  chk_div_phase: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 (phase <= $past(div_code)) || $changed(div_code))
    else $error("port clock phase ran past the divide code");
  chk_clk_drive: assert property (@(posedge pclk) disable iff (!presetn)
    port_clk_oe_n == !master)
    else $error("port clock driven without master mode");
endmodule

// file: logic/rxops_pkg.sv
// Types shared by the receiver output port select block.
// Assumes nothing beyond SystemVerilog packed types.
package rxops_pkg;

  // One output word with its side indicators
  typedef struct packed {
    logic [15:0] data;
    logic        iq;
    logic [1:0]  chan;
  } rxops_word_t;

  // Per-path emission sequencer
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_SEND
  } rxops_state_t;

endpackage

// file: logic/rxops_top.sv
// Output path A and B routing: source select, format and link framing.
// Assumes channel and AGC triggers are one-cycle pulses with data valid.
`timescale 1ns/1ps
`include "rxops_cfg.svh"

module rxops_top
  import rxops_pkg::*;
#(
  parameter int DATA_W = 16
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic [3:0]              ch_trig,
  input  wire logic [4*DATA_W-1:0]     ch_i,
  input  wire logic [4*DATA_W-1:0]     ch_q,
  input  wire logic [1:0]              agc_trig,
  input  wire logic [2*DATA_W-1:0]     agc_i,
  input  wire logic [2*DATA_W-1:0]     agc_q,
  input  wire logic [2*DATA_W-1:0]     agc_gain,
  output rxops_pkg::rxops_word_t [1:0] par_word,
  output logic [1:0]                   par_valid,
  input  wire logic [1:0]              par_ready,
  output logic [15:0]                  lnk_byte,
  output logic [1:0]                   lnk_valid,
  input  wire logic [1:0]              lnk_ready,
  input  wire logic                    port_clk_i,
  output logic                         port_clk_o,
  output logic                         port_clk_oe_n
);
  import rxops_pkg::*;

  // Byte lanes and packed format assume 16-bit samples
  if (DATA_W != 16) begin : g_width_check
    $error("rxops_top serves 16-bit samples only");
  end

  // Control registers, one parallel and one link per path
  logic [7:0] par_ctl [2];
  logic [7:0] lnk_ctl [2];
  logic [7:0] clk_ctl;

  // Source latches: channels 0..3, then AGC A and B
  logic [15:0] src_i [6];
  logic [15:0] src_q [6];
  logic [15:0] src_g [2];
  wire  [5:0]  trig = {agc_trig, ch_trig};

  // Per-path state seen by the status register
  rxops_state_t st   [2];
  logic [5:0]   pend [2];
  logic [1:0]   obusy;

  // APB decode; zero wait states, unmapped index answers an error
  wire [5:0] idx    = paddr[7:2];
  wire       acc    = psel & penable;
  wire       hit    = (idx >= `RXOPS_IDX_PAR_A) && (idx <= `RXOPS_IDX_STATUS);
  wire       wr     = acc & pwrite & hit;
  assign pready  = 1'b1;
  assign pslverr = acc & ~hit;

  // Read mux; status shows sequencer activity and the sampled port clock
  wire [7:0] status = {port_clk_i, obusy, 1'b0, st[1] != ST_IDLE, st[0] != ST_IDLE,
                       |pend[1], |pend[0]};
  always_comb begin
    prdata = 32'h0000_0000;
    case (idx)
      `RXOPS_IDX_PAR_A:  prdata[7:0] = par_ctl[0];
      `RXOPS_IDX_LNK_A:  prdata[7:0] = lnk_ctl[0];
      `RXOPS_IDX_PAR_B:  prdata[7:0] = par_ctl[1];
      `RXOPS_IDX_LNK_B:  prdata[7:0] = lnk_ctl[1];
      `RXOPS_IDX_CLK:    prdata[7:0] = clk_ctl;
      `RXOPS_IDX_STATUS: prdata[7:0] = status;
      default:           prdata = 32'h0000_0000;
    endcase
  end

  // Register writes take effect on the access edge only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      par_ctl[0] <= `RXOPS_REG_RESET;
      lnk_ctl[0] <= `RXOPS_REG_RESET;
      par_ctl[1] <= `RXOPS_REG_RESET;
      lnk_ctl[1] <= `RXOPS_REG_RESET;
      clk_ctl    <= `RXOPS_REG_RESET;
    end else if (wr) begin
      case (idx)
        `RXOPS_IDX_PAR_A: par_ctl[0] <= pwdata[7:0];
        `RXOPS_IDX_LNK_A: lnk_ctl[0] <= pwdata[7:0];
        `RXOPS_IDX_PAR_B: par_ctl[1] <= pwdata[7:0];
        `RXOPS_IDX_LNK_B: lnk_ctl[1] <= pwdata[7:0];
        `RXOPS_IDX_CLK:   clk_ctl    <= pwdata[7:0];
        default:          clk_ctl    <= clk_ctl;
      endcase
    end
  end

  // Latch each source on its trigger; a source retriggered before
  // its word is taken overwrites the older sample
  always_ff @(posedge pclk) begin
    for (int s = 0; s < 4; s++) begin
      if (ch_trig[s]) begin
        src_i[s] <= ch_i[s*DATA_W +: DATA_W];
        src_q[s] <= ch_q[s*DATA_W +: DATA_W];
      end
    end
    for (int a = 0; a < 2; a++) begin
      if (agc_trig[a]) begin
        src_i[4+a] <= agc_i[a*DATA_W +: DATA_W];
        src_q[4+a] <= agc_q[a*DATA_W +: DATA_W];
        src_g[a]   <= agc_gain[a*DATA_W +: DATA_W];
      end
    end
  end

  // Port clock source and divider
  rxops_clkdiv u_clkdiv (
    .pclk          (pclk),
    .presetn       (presetn),
    .div_code      (clk_ctl[`RXOPS_DIV_MSB:`RXOPS_DIV_LSB]),
    .master        (clk_ctl[`RXOPS_BIT_MASTER]),
    .port_clk_o    (port_clk_o),
    .port_clk_oe_n (port_clk_oe_n)
  );

  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_path
      logic [1:0]  rr;
      logic [2:0]  sel;
      logic [3:0]  cnt;
      logic [3:0]  wcnt;
      logic [3:0]  nwords;
      logic        narrow;
      logic [15:0] hi_i;
      logic [15:0] hi_q;
      logic [15:0] hi_g;
      rxops_word_t ow;
      logic        ov;
      logic        bph;

      // Mode decode from the live control bits
      wire       link   = lnk_ctl[p][`RXOPS_BIT_LNK_EN];
      wire [7:0] pc     = par_ctl[p];
      wire [7:0] lc     = lnk_ctl[p];
      wire       l_agc  = lc[`RXOPS_BIT_SRC];
      wire       l_mode = lc[`RXOPS_BIT_MODE];
      // Enable fields start at bit 1: two AGC bits or four channel bits
      wire [5:0] p_mask = pc[`RXOPS_BIT_SRC]
                        ? {pc[`RXOPS_AGC_EN_MSB:`RXOPS_EN_LSB], 4'h0}
                        : {2'b00, pc[`RXOPS_CH_EN_MSB:`RXOPS_EN_LSB]};
      // Link serves one expected source at a time, in fixed rotation or the path's own AGC
      wire [2:0] l_tgt  = !l_agc ? {1'b0, rr}
                        : l_mode ? (`RXOPS_AGC_BASE + 3'(p))
                                 : (`RXOPS_AGC_BASE + {2'b00, rr[0]});
      wire [5:0] mask   = link ? (6'h01 << l_tgt) : p_mask;
      wire [5:0] ready  = pend[p] & mask;
      // Lowest index wins when triggers coincide
      wire [2:0] pick   = ready[0] ? 3'h0 : ready[1] ? 3'h1 : ready[2] ? 3'h2 :
                          ready[3] ? 3'h3 : ready[4] ? 3'h4 : 3'h5;
      wire       take   = (st[p] == ST_IDLE) && (ready != 6'h00);
      // Gain words only with AGC data on the link; bit 2 ignored otherwise
      wire       gain   = link & l_agc & ~lc[`RXOPS_BIT_NOGAIN];
      wire [3:0] dly    = lc[`RXOPS_DLY_MSB:`RXOPS_DLY_LSB];
      // Delays below the receiver's floor are raised to it
      wire [3:0] dly_ld = (dly < `RXOPS_DELAY_MIN) ? `RXOPS_DELAY_MIN : dly;
      wire       last_w = (wcnt == nwords - 4'h1);

      // Word being offered to the buffer
      rxops_word_t nw;
      always_comb begin
        nw.chan = sel[1:0];
        nw.iq   = narrow | (wcnt == 4'h0);
        case (wcnt)
          4'h0:    nw.data = narrow ? {hi_i[15:8], hi_q[15:8]} : hi_i;
          4'h1:    nw.data = hi_q;
          4'h2:    nw.data = hi_g;
          default: nw.data = 16'h0000;
        endcase
      end

      wire         push = (st[p] == ST_SEND);
      wire         in_rdy;
      rxops_word_t bw;
      wire         bv;
      wire         pop_ok = ~ov | (link ? (bph & lnk_ready[p]) : par_ready[p]);

      // Two-entry buffer absorbs a receiver stall
      rxops_buf #(
        .W     ($bits(rxops_word_t)),
        .DEPTH (2)
      ) u_buf (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_data   (nw),
        .in_valid  (push),
        .in_ready  (in_rdy),
        .out_data  (bw),
        .out_valid (bv),
        .out_ready (pop_ok)
      );

      // Pending flags: a trigger wins over the clear in the same cycle
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pend[p] <= 6'h00;
        end else begin
          pend[p] <= (pend[p] & ~(take ? (6'h01 << pick) : 6'h00)) | trig;
        end
      end

      // Sequencer: take a source, wait out the link delay, emit its words
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          st[p]  <= ST_IDLE;
          rr     <= 2'h0;
          sel    <= 3'h0;
          cnt    <= 4'h0;
          wcnt   <= 4'h0;
          nwords <= `RXOPS_IQ_WORDS;
          narrow <= 1'b0;
        end else begin
          case (st[p])
            ST_IDLE: begin
              if (take) begin
                sel    <= pick;
                narrow <= ~link & pc[`RXOPS_BIT_FMT];
                nwords <= (~link & pc[`RXOPS_BIT_FMT]) ? 4'h1
                        : gain ? `RXOPS_QUAD_WORDS : `RXOPS_IQ_WORDS;
                cnt    <= dly_ld - 4'h1;
                wcnt   <= 4'h0;
                st[p]  <= link ? ST_WAIT : ST_SEND;
              end
            end
            ST_WAIT: begin
              cnt <= cnt - 4'h1;
              if (cnt == 4'h0) begin
                st[p] <= ST_SEND;
              end
            end
            ST_SEND: begin
              if (in_rdy) begin
                wcnt <= wcnt + 4'h1;
                if (last_w) begin
                  st[p] <= ST_IDLE;
                  // Rotation wraps at two or four sources
                  rr <= (!l_agc && l_mode) ? rr + 2'h1 : {1'b0, ~rr[0]};
                end
              end
            end
            default: st[p] <= ST_IDLE;
          endcase
        end
      end

      // Snapshot of the chosen source, taken with it
      always_ff @(posedge pclk) begin
        if (take) begin
          hi_i <= src_i[pick];
          hi_q <= src_q[pick];
          hi_g <= pick[0] ? src_g[1] : src_g[0];
        end
      end

      // Output word stage; link sends low byte first, then high
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ov  <= 1'b0;
          ow  <= '0;
          bph <= 1'b0;
        end else begin
          if (link && ov && lnk_ready[p]) begin
            bph <= ~bph;
          end
          if (pop_ok) begin
            ov <= bv;
            ow <= bw;
          end
        end
      end

      // Only the enabled interface sees the stream
      assign par_word[p]             = ow;
      assign par_valid[p]            = ov & ~link;
      assign lnk_valid[p]            = ov & link;
      assign lnk_byte[p*8 +: 8]      = bph ? ow.data[15:8] : ow.data[7:0];
      assign obusy[p]                = ov;

      chk_port_excl: assert property (@(posedge pclk) disable iff (!presetn)
        !(par_valid[p] && lnk_valid[p]))
        else $error("parallel and link ports both active");
      chk_par_enable: assert property (@(posedge pclk) disable iff (!presetn)
        (take && !link && pc[0]) |-> pick >= 3'h4 && pc[pick - 3'h3])
        else $error("AGC word taken without its enable bit");
      chk_chan_enable: assert property (@(posedge pclk) disable iff (!presetn)
        (take && !link && !pc[0]) |-> pick < 3'h4 && pc[pick + 3'h1])
        else $error("channel word taken without its enable bit");
      chk_trig_kept: assert property (@(posedge pclk) disable iff (!presetn)
        trig[0] |=> pend[p][0])
        else $error("trigger lost on its clear cycle");
      chk_narrow_iq: assert property (@(posedge pclk) disable iff (!presetn)
        (push && narrow) |-> nw.iq && last_w)
        else $error("packed word without IQ high or single word");
      chk_link_order: assert property (@(posedge pclk) disable iff (!presetn)
        (take && link && !l_agc) |-> pick == {1'b0, rr} && (l_mode || rr < 2'h2))
        else $error("link channel out of rotation");
      chk_start_delay: assert property (@(posedge pclk) disable iff (!presetn)
        (take && link) |=> (st[p] == ST_WAIT) [*6])
        else $error("link word launched before the delay floor");
      chk_gain_pad: assert property (@(posedge pclk) disable iff (!presetn)
        (push && wcnt > 4'h2) |-> nw.data == 16'h0000 && nwords == `RXOPS_QUAD_WORDS)
        else $error("quad-word padding not zero");
      chk_wait_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (st[p] == ST_WAIT && cnt != 4'h0) |=> st[p] == ST_WAIT)
        else $error("link word launched before its delay count expired");
    end
  endgenerate
endmodule

// file: tb/rxops_sink.sv
// Far-side capture model: a DSP or FPGA taking parallel words and link bytes.
// Assumes the bench empties its queues between tests.
`timescale 1ns/1ps
module rxops_sink
  import rxops_pkg::*;
(
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic [1:0]              mode,
  input  wire rxops_pkg::rxops_word_t [1:0] par_word,
  input  wire logic [1:0]              par_valid,
  output logic [1:0]                   par_ready,
  input  wire logic [15:0]             lnk_byte,
  input  wire logic [1:0]              lnk_valid,
  output logic [1:0]                   lnk_ready,
  output logic                         port_clk_i
);
  rxops_word_t pq[2][$];
  logic [7:0]  lq[2][$];

  // Mode 0 always ready, 1 random stalls drawn each cycle, 2 full parallel stall; link ready is random in modes 1 and 2

  // Capture only on a completed handshake
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      par_ready  <= 2'b00;
      lnk_ready  <= 2'b00;
      port_clk_i <= 1'b0;
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (par_valid[p] && par_ready[p]) pq[p].push_back(par_word[p]);
        if (lnk_valid[p] && lnk_ready[p]) lq[p].push_back(lnk_byte[8*p+:8]);
      end
      par_ready  <= (mode == 2'd0) ? 2'b11 : (mode == 2'd1) ? 2'($urandom) : 2'b00;
      lnk_ready  <= 2'($urandom) | {2{mode == 2'd0}};
      // External port clock runs only while words are offered
      port_clk_i <= |{par_valid, lnk_valid} ? ~port_clk_i : 1'b0;
    end
  end
endmodule

// file: tb/tb.sv
// Self-checking bench for the output port select block.
// Assumes the capture model in rxops_sink and APB register access.
`timescale 1ns/1ps
module tb;
  import rxops_pkg::*;
  logic              pclk      = 1'b0;
  logic              presetn   = 1'b0;
  logic              psel      = 1'b0;
  logic              penable   = 1'b0;
  logic              pwrite    = 1'b0;
  logic [7:0]        paddr     = 8'h00;
  logic [31:0]       pwdata    = 32'h0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [3:0]        ch_trig   = 4'h0;
  logic [63:0]       ch_i      = 64'h0;
  logic [63:0]       ch_q      = 64'h0;
  logic [1:0]        agc_trig  = 2'h0;
  logic [31:0]       agc_i     = 32'h0;
  logic [31:0]       agc_q     = 32'h0;
  logic [31:0]       agc_gain  = 32'h0;
  rxops_word_t [1:0] par_word;
  logic [1:0]        par_valid;
  logic [1:0]        par_ready;
  logic [15:0]       lnk_byte;
  logic [1:0]        lnk_valid;
  logic [1:0]        lnk_ready;
  logic              port_clk_i;
  logic              port_clk_o;
  logic              port_clk_oe_n;
  logic [1:0]        sink_mode = 2'd1;
  logic [63:0]       ci        = 64'h0;
  logic [63:0]       cq        = 64'h0;
  logic [31:0]       ai        = 32'h0;
  logic [31:0]       aq        = 32'h0;
  logic [31:0]       ag        = 32'h0;
  logic [31:0]       r;
  logic              e;
  logic              prev;
  logic              src;
  logic              fmt;
  logic [3:0]        en;
  logic [3:0]        m;
  logic [7:0]        v;
  int                p;
  int                c;
  int                n;
  int                lat[3];
  rxops_word_t       ep[2][$];
  logic [7:0]        el[2][$];
  int                bad_count   = 0;
  int                comparisons = 0;

  // 200 MHz clock
  always #2.5 pclk = ~pclk;

  rxops_top #(.DATA_W(16)) rxops_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ch_trig(ch_trig), .ch_i(ch_i), .ch_q(ch_q), .agc_trig(agc_trig), .agc_i(agc_i),
    .agc_q(agc_q), .agc_gain(agc_gain), .par_word(par_word), .par_valid(par_valid),
    .par_ready(par_ready), .lnk_byte(lnk_byte), .lnk_valid(lnk_valid),
    .lnk_ready(lnk_ready), .port_clk_i(port_clk_i), .port_clk_o(port_clk_o),
    .port_clk_oe_n(port_clk_oe_n));

  rxops_sink rxops_sink_inst (
    .pclk(pclk), .presetn(presetn), .mode(sink_mode), .par_word(par_word),
    .par_valid(par_valid), .par_ready(par_ready), .lnk_byte(lnk_byte),
    .lnk_valid(lnk_valid), .lnk_ready(lnk_ready), .port_clk_i(port_clk_i));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic reset_dut(input int k);
    presetn <= 1'b0;
    repeat (k) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd_v, output logic err);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_v = prdata;
    err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, r, e);
    check(r, x);
  endtask

  task automatic fire_ch(input logic [3:0] mk_t);
    ci = {$urandom, $urandom};
    cq = {$urandom, $urandom};
    ch_i    <= ci;
    ch_q    <= cq;
    ch_trig <= mk_t;
    @(posedge pclk);
    ch_trig <= 4'h0;
    @(posedge pclk);
  endtask

  // Only the fired lane gets new data so earlier samples stay known
  task automatic fire_agc(input logic [1:0] m2);
    for (int a = 0; a < 2; a++)
      if (m2[a]) begin
        ai[16*a+:16] = 16'($urandom);
        aq[16*a+:16] = 16'($urandom);
        ag[16*a+:16] = 16'($urandom);
      end
    agc_i    <= ai;
    agc_q    <= aq;
    agc_gain <= ag;
    agc_trig <= m2;
    @(posedge pclk);
    agc_trig <= 2'h0;
    @(posedge pclk);
  endtask

  function automatic rxops_word_t mk(input logic [15:0] d, input logic iq, input logic [1:0] ch);
    mk = '{data: d, iq: iq, chan: ch};
  endfunction

  task automatic exp_par(input int pp, input logic f, input logic [15:0] i,
                         input logic [15:0] q, input logic [1:0] ch);
    if (f) ep[pp].push_back(mk({i[15:8], q[15:8]}, 1'b1, ch));
    else begin
      ep[pp].push_back(mk(i, 1'b1, ch));
      ep[pp].push_back(mk(q, 1'b0, ch));
    end
  endtask

  task automatic exp_lw(input int pp, input logic [15:0] w);
    el[pp].push_back(w[7:0]);
    el[pp].push_back(w[15:8]);
  endtask

  // Waits for the expected count, then also catches surplus words
  task automatic match();
    int k;
    for (int pp = 0; pp < 2; pp++) begin
      k = 0;
      while ((rxops_sink_inst.pq[pp].size() < ep[pp].size() ||
              rxops_sink_inst.lq[pp].size() < el[pp].size()) && k < 500) begin
        @(posedge pclk);
        k++;
      end
    end
    repeat (30) @(posedge pclk);
    for (int pp = 0; pp < 2; pp++) begin
      check(rxops_sink_inst.pq[pp].size(), ep[pp].size());
      check(rxops_sink_inst.lq[pp].size(), el[pp].size());
      foreach (ep[pp][i])
        if (i < rxops_sink_inst.pq[pp].size()) check(rxops_sink_inst.pq[pp][i], ep[pp][i]);
      foreach (el[pp][i])
        if (i < rxops_sink_inst.lq[pp].size()) check(rxops_sink_inst.lq[pp][i], el[pp][i]);
      rxops_sink_inst.pq[pp].delete();
      rxops_sink_inst.lq[pp].delete();
      ep[pp].delete();
      el[pp].delete();
    end
  endtask

  // Watchdog sized well beyond the expected run
  initial begin
    #300000;
    bad_count++;
    test_done();
  end

  initial begin
    void'($urandom(32'haedd));
    reset_dut(4);
    for (int k = 0; k < 5; k++) begin
      v = 8'($urandom);
      rd(8'(8'h68 + 4*k), 32'h0);
      wr(8'(8'h68 + 4*k), {24'h0, v});
      rd(8'(8'h68 + 4*k), {24'h0, v});
    end
    apb(1'b0, 8'h00, 32'h0, r, e);
    check({31'h0, e}, 32'h1);
    check(r, 32'h0);
    $display("test registers ends, bad_count=%0d", bad_count);
    // Parallel paths: channel and AGC sources, both formats, stalls
    for (int k = 0; k < 16; k++) begin
      reset_dut(2);
      p = k % 2;
      src = 1'($urandom);
      fmt = 1'($urandom);
      en = 4'($urandom);
      sink_mode <= (k < 2) ? 2'd2 : 2'd1;
      wr(8'(8'h68 + 8*p), {26'h0, fmt, en, src});
      if (src == 1'b0) begin
        m = 4'($urandom);
        fire_ch(m);
        for (int s = 0; s < 4; s++)
          if (m[s] && en[s]) exp_par(p, fmt, ci[16*s+:16], cq[16*s+:16], 2'(s));
      end else begin
        fire_agc(2'b10);
        fire_agc(2'b01);
        if (en[1]) exp_par(p, fmt, ai[31:16], aq[31:16], 2'd1);
        if (en[0]) exp_par(p, fmt, ai[15:0], aq[15:0], 2'd0);
      end
      if (k < 2) begin
        repeat (20) @(posedge pclk);
        sink_mode <= 2'd1;
      end
      match();
    end
    $display("test parallel ends, bad_count=%0d", bad_count);
    // Link modes: two and four channels, own AGC with gain, alternating AGC
    for (int k = 0; k < 10; k++) begin
      reset_dut(2);
      p = k % 2;
      c = k / 2;
      if (c < 2) begin
        wr(8'(8'h6c + 8*p), {24'h0, 5'h10, 1'($urandom), c[0], 1'b0});
        fire_ch(4'hf);
        for (int s = 0; s < (c == 1 ? 4 : 2); s++) begin
          exp_lw(p, ci[16*s+:16]);
          exp_lw(p, cq[16*s+:16]);
        end
      end else begin
        wr(8'(8'h6c + 8*p), {24'h0, 5'h10, c == 4, c == 2, 1'b1});
        fire_agc(2'b11);
        for (int a = 0; a < 2; a++)
          if (c != 2 || a == p) begin
            exp_lw(p, ai[16*a+:16]);
            exp_lw(p, aq[16*a+:16]);
            if (c != 4) begin
              exp_lw(p, ag[16*a+:16]);
              repeat (5) exp_lw(p, 16'h0);
            end
          end
      end
      match();
    end
    $display("test link ends, bad_count=%0d", bad_count);
    // Start delay: a short setting is raised to the floor
    sink_mode <= 2'd0;
    for (int k = 0; k < 3; k++) begin
      reset_dut(2);
      wr(8'h6c, {24'h0, 1'b1, 4'(6 * k), 3'h0});
      fire_ch(4'h1);
      n = 0;
      while (lnk_valid[0] !== 1'b1 && n < 100) begin
        @(posedge pclk);
        n++;
      end
      lat[k] = n;
      exp_lw(0, ci[15:0]);
      exp_lw(0, cq[15:0]);
      match();
    end
    check(lat[1], lat[0]);
    check(lat[2] - lat[1], 32'd6);
    check(32'(lat[1] >= 5), 32'h1);
    $display("test delay ends, bad_count=%0d", bad_count);
    // Port clock: master drive and divide by code plus one
    for (int k = 0; k < 4; k++) begin
      wr(8'h78, {29'h0, 2'(k), 1'b1});
      repeat (4) @(posedge pclk);
      check({31'h0, port_clk_oe_n}, 32'h0);
      n = 0;
      prev = port_clk_o;
      repeat (24) begin
        @(posedge pclk);
        if (port_clk_o && !prev) n++;
        prev = port_clk_o;
      end
      if (k > 0) check(n, 24 / (k + 1));
    end
    wr(8'h78, 32'h0);
    @(posedge pclk);
    check({31'h0, port_clk_oe_n}, 32'h1);
    $display("test clock ends, bad_count=%0d", bad_count);
    test_done();
  end
endmodule
